// file: logic/ssi_pkg.sv
// shared constants and types for the supply switchover and supply interrupt block
package ssi_pkg;

  // register offsets on the special function register port
  localparam logic [7:0] SSI_ADDR_CORE_IRQ_EN2 = 8'hA9;
  localparam logic [7:0] SSI_ADDR_CONV_START = 8'hD8;
  localparam logic [7:0] SSI_ADDR_SUPPLY_IRQ_EN = 8'hEC;
  localparam logic [7:0] SSI_ADDR_PERIPHERAL_CONFIG_CFG = 8'hF4;
  localparam logic [7:0] SSI_ADDR_SWITCHOVER_CFG = 8'hF5;
  localparam logic [7:0] SSI_ADDR_SUPPLY_IRQ_FLAGS = 8'hF8;
  localparam logic [7:0] SSI_ADDR_BAT_THRESHOLD = 8'hFA;
  localparam logic [7:0] SSI_ADDR_IRQ_PIN_CFG = 8'hFF;

  // field positions
  localparam int SSI_BIT_CORE_EN = 1;
  localparam int SSI_BIT_SRC_IND = 6;
  localparam int SSI_SRC_SEL_LSB = 0;
  localparam int SSI_PIN1_LSB = 1;

  // switchover source select codes
  localparam logic [1:0] SSI_SRC_MAIN_ONLY = 2'h0;
  localparam logic [1:0] SSI_SRC_DC_INPUT = 2'h1;
  // irq pin one setup low two bits that enable the battery control pin
  localparam logic [1:0] SSI_PIN1_BATTERY_CTRL = 2'h1;

  // values after reset
  localparam logic [7:0] SSI_RST_CORE_IRQ_EN2 = 8'h00;
  localparam logic [7:0] SSI_RST_SUPPLY_IRQ_EN = 8'h00;
  localparam logic [7:0] SSI_RST_PERIPHERAL_CONFIG_CFG = 8'h00;
  localparam logic [7:0] SSI_RST_SWITCHOVER_CFG = 8'h00;
  localparam logic [7:0] SSI_RST_SUPPLY_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] SSI_RST_BAT_THRESHOLD = 8'h00;
  localparam logic [7:0] SSI_RST_IRQ_PIN_CFG = 8'h00;

  // implemented bits of the enable and flag registers
  localparam logic [7:0] SSI_EVENT_BITS = 8'hAF;
  // sources missing on the reduced-feature variant
  localparam logic [7:0] SSI_MONITOR_BITS = 8'h0D;

  // restore qualification time and its cycle count at 125 MHz
  localparam int unsigned SSI_CLK_FREQ_KHZ = 125_000;
  localparam int unsigned SSI_QUAL_TIME_MS = 130;
  localparam int unsigned SSI_QUAL_CYCLES_DEF = SSI_QUAL_TIME_MS * SSI_CLK_FREQ_KHZ;

  // supply event flags, same layout for enable and flag registers
  typedef struct packed {
    logic restore;
    logic summary;
    logic line_dip;
    logic rsvd4;
    logic dc_delta;
    logic bat_mon;
    logic switchover;
    logic dc_low;
  } ssi_events_s;

  // register port request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssi_sfr_req_s;

  // analog front end events, synchronous to clk
  typedef struct packed {
    logic line_dip;
    logic dc_delta;
    logic dc_ready;
    logic bat_valid;
    logic [7:0] bat_result;
  } ssi_adc_s;

  typedef enum logic [1:0] {
    SSI_ON_MAIN,
    SSI_ON_BATTERY,
    SSI_QUALIFY
  } ssi_state_e;

endpackage

// file: logic/ssi_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module ssi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: logic/ssi_top.sv
// supply source switchover control and shared supply event interrupt
`timescale 1ns/1ps
// How it works
// R1: select 01: dc input below 1.2 V moves supply to battery.
// R2: select 00: only main supply comparator at 2.75 V decides switchover.
// R3: pin setup X01: battery control pin falling edge forces battery anytime; the code ignores the edge while select is 1x.
// R4: return to main only when all enabled restore conditions hold; the code returns to main at once when select is set to 1x.
// R5: dc input switchover enabled: restore also needs dc input above 1.2 V.
// R6: battery control pin enabled: restore also needs that pin high.
// R7: restore waits about 130 ms of qualified conditions before switching.
// R8: shared interrupt masked after reset, gated by core-level enable bit.
// R9: per-source enable bits choose which latched flags reach the interrupt.
// R10: switchover and restore flags set regardless of enables, cleared by 0.
// R11: main to battery sets switchover flag; interrupt only when enabled.
// R12: battery to main sets restore flag; interrupt only when enabled.
// R13: source indicator bit 6 reads 1 on main, 0 on battery.
// R14: dc input delta event sets its flag; enable gates the interrupt.
// R15: software write starts a conversion; result ready sets delta flag.
// R16: battery result ready or below threshold sets battery flag.
// R17: dc input below 1.2 V sets its flag; enable gates interrupt.
// R18: reduced variant lacks delta, battery and dc input comparator sources.
// R19: line dip event sets its flag; enable gates the interrupt.
// R20: interrupt is core enable and OR of flags anded with enables.
// R21: comparators and pin synchronised before edge detection and flag setting.
module ssi_top import ssi_pkg::*; #(
  parameter int unsigned QUAL_CYCLES = SSI_QUAL_CYCLES_DEF,
  parameter bit HAS_MONITORS = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // special function register port
  input wire ssi_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata_r,
  // comparators and battery control pin, asynchronous
  input wire logic main_above_th,
  input wire logic dc_above_th,
  input wire logic battery_control_pin,
  // monitor converters and line dip detector
  input wire ssi_adc_s adc_in,
  output logic conv_start_r,
  // supply switch and core interrupt
  output logic supply_on_main_r,
  output logic supply_irq_r
);
  // qualify counter wide enough for the full wait
  localparam int QW = $clog2(QUAL_CYCLES + 1);
  // count at which the wait ends
  localparam logic [QW-1:0] QUAL_LAST = QW'(QUAL_CYCLES - 1);
  localparam logic [7:0] FLAG_MASK = HAS_MONITORS ? SSI_EVENT_BITS : (SSI_EVENT_BITS & ~SSI_MONITOR_BITS);

  // reset release through two flops
  // assertion is immediate; removal is aligned to clk
  logic [1:0] rst_pipe_r;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // synchronised comparator and pin levels
  // reset value 1 reads as supply good and pin idle high,
  // so no trip and no false pin edge follow reset
  logic main_ok;
  logic dc_ok;
  logic pin_hi;
  logic pin_hi_d_r;

  ssi_sync #(
    .WIDTH(3),
    .INIT(3'h7)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({main_above_th, dc_above_th, battery_control_pin}),
    .q({main_ok, dc_ok, pin_hi})
  ); // [R21]

  // previous pin level for falling-edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_hi_d_r <= 1'b1;
    end else begin
      pin_hi_d_r <= pin_hi;
    end
  end

  // registers
  logic [7:0] core_en2_r;
  logic [7:0] supply_en_r;
  logic [7:0] peripheral_config_r;
  logic [7:0] switch_cfg_r;
  ssi_events_s flags_r;
  logic [7:0] bat_thr_r;
  logic [7:0] pin_cfg_r;

  // write decode
  // a strobe to an unmapped address changes nothing
  wire wr_core_en2 = sfr_req.wr && (sfr_req.addr == SSI_ADDR_CORE_IRQ_EN2);
  wire wr_supply_en = sfr_req.wr && (sfr_req.addr == SSI_ADDR_SUPPLY_IRQ_EN);
  wire wr_peripheral_config = sfr_req.wr && (sfr_req.addr == SSI_ADDR_PERIPHERAL_CONFIG_CFG);
  wire wr_switch_cfg = sfr_req.wr && (sfr_req.addr == SSI_ADDR_SWITCHOVER_CFG);
  wire wr_flags = sfr_req.wr && (sfr_req.addr == SSI_ADDR_SUPPLY_IRQ_FLAGS);
  wire wr_bat_thr = sfr_req.wr && (sfr_req.addr == SSI_ADDR_BAT_THRESHOLD);
  wire wr_pin_cfg = sfr_req.wr && (sfr_req.addr == SSI_ADDR_IRQ_PIN_CFG);
  wire wr_conv = sfr_req.wr && (sfr_req.addr == SSI_ADDR_CONV_START);

  // configuration fields
  // select 1x turns switchover off; pin setup X01 needs only bits 2:1
  wire [1:0] src_sel = switch_cfg_r[SSI_SRC_SEL_LSB +: 2];
  wire switch_off = src_sel[1];
  wire dc_sel = (src_sel == SSI_SRC_DC_INPUT);
  wire main_sel = (src_sel == SSI_SRC_MAIN_ONLY);
  wire pin_en = (pin_cfg_r[SSI_PIN1_LSB +: 2] == SSI_PIN1_BATTERY_CTRL);
  wire core_en = core_en2_r[SSI_BIT_CORE_EN];

  // switchover and restore conditions
  // select 01 trips on dc input or main low
  // a pin edge is ignored while switchover is off
  wire pin_fall = pin_en && pin_hi_d_r && !pin_hi; // [R3]
  wire main_low_trip = (main_sel || dc_sel) && !main_ok; // [R2]
  wire dc_low_trip = dc_sel && !dc_ok; // [R1]
  wire go_battery = !switch_off && (main_low_trip || dc_low_trip || pin_fall);
  wire restore_main = main_ok; // [R4]
  wire restore_dc = !dc_sel || (dc_ok && main_ok); // [R5]
  wire restore_pin = !pin_en || pin_hi; // [R6]
  wire restore_ok = switch_off || (restore_main && restore_dc && restore_pin); // [R4]

  // supply source state machine
  // the wait counts edges with every restore condition held
  // any lost restore condition during the wait starts it over
  ssi_state_e state_r;
  ssi_state_e state_nxt;
  logic [QW-1:0] qual_cnt_r;
  logic [QW-1:0] qual_cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    qual_cnt_nxt = qual_cnt_r;
    case (state_r)
      SSI_ON_MAIN: begin
        if (go_battery) begin
          state_nxt = SSI_ON_BATTERY;
        end
      end
      SSI_ON_BATTERY: begin
        // no restore while a trip condition is still present
        qual_cnt_nxt = '0;
        if (switch_off) begin
          state_nxt = SSI_ON_MAIN;
        end else if (restore_ok && !go_battery) begin
          state_nxt = SSI_QUALIFY;
        end
      end
      SSI_QUALIFY: begin
        if (switch_off) begin
          state_nxt = SSI_ON_MAIN;
        end else if (!restore_ok || go_battery) begin
          state_nxt = SSI_ON_BATTERY;
        end else if (qual_cnt_r == QUAL_LAST) begin
          state_nxt = SSI_ON_MAIN; // [R7]
        end else begin
          qual_cnt_nxt = qual_cnt_r + QW'(1); // [R7]
        end
      end
      default: begin
        state_nxt = SSI_ON_MAIN;
        qual_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SSI_ON_MAIN;
      qual_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      qual_cnt_r <= qual_cnt_nxt;
    end
  end

  // source change events
  // edges follow the registered source, so each change is seen once
  wire on_main_nxt = (state_nxt == SSI_ON_MAIN);
  wire to_battery = supply_on_main_r && !on_main_nxt;
  wire to_main = !supply_on_main_r && on_main_nxt;

  // flag set and clear; a set in the clearing cycle wins
  // the summary bit is never stored; it is rebuilt on read
  ssi_events_s flag_set;
  ssi_events_s flags_nxt;
  ssi_events_s en_s;
  logic [7:0] flag_clr;
  logic [7:0] pending;

  always_comb begin
    flag_set = '0;
    flag_set.switchover = to_battery; // [R10] [R11]
    flag_set.restore = to_main; // [R10] [R12]
    flag_set.line_dip = adc_in.line_dip; // [R19]
    flag_set.dc_delta = adc_in.dc_delta || adc_in.dc_ready; // [R14] [R15]
    // a fresh result covers the below-threshold case as well
    flag_set.bat_mon = adc_in.bat_valid || (adc_in.bat_valid && (adc_in.bat_result < bat_thr_r)); // [R16]
    // re-set every cycle while the input stays low
    flag_set.dc_low = !dc_ok; // [R17]
  end

  // writing 0 clears a flag, writing 1 keeps it
  assign flag_clr = wr_flags ? ~sfr_req.wdata : 8'h00; // [R10]
  assign flags_nxt = ((flags_r & ~flag_clr) | flag_set) & FLAG_MASK; // [R18]
  assign en_s = supply_en_r & FLAG_MASK; // [R18]
  assign pending = flags_r & en_s; // [R9]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= SSI_RST_SUPPLY_IRQ_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // software written registers
  // enables of missing sources stay zero on the reduced variant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_en2_r <= SSI_RST_CORE_IRQ_EN2; // [R8]
      supply_en_r <= SSI_RST_SUPPLY_IRQ_EN;
      peripheral_config_r <= SSI_RST_PERIPHERAL_CONFIG_CFG;
      switch_cfg_r <= SSI_RST_SWITCHOVER_CFG; // [R1]
      bat_thr_r <= SSI_RST_BAT_THRESHOLD;
      pin_cfg_r <= SSI_RST_IRQ_PIN_CFG;
    end else begin
      if (wr_core_en2) begin
        core_en2_r <= sfr_req.wdata;
      end
      if (wr_supply_en) begin
        supply_en_r <= sfr_req.wdata & FLAG_MASK;
      end
      if (wr_peripheral_config) begin
        peripheral_config_r <= sfr_req.wdata;
      end
      if (wr_switch_cfg) begin
        switch_cfg_r <= sfr_req.wdata;
      end
      if (wr_bat_thr) begin
        bat_thr_r <= sfr_req.wdata;
      end
      if (wr_pin_cfg) begin
        pin_cfg_r <= sfr_req.wdata;
      end
    end
  end

  // read data, registered one cycle after the strobe
  // a read and a write in one cycle return the old value
  logic [7:0] peripheral_config_view;
  ssi_events_s flags_view;
  logic [7:0] rdata_nxt;

  always_comb begin
    peripheral_config_view = peripheral_config_r;
    peripheral_config_view[SSI_BIT_SRC_IND] = supply_on_main_r; // [R13]
    flags_view = flags_r;
    flags_view.summary = |pending;
  end

  always_comb begin
    case (sfr_req.addr)
      SSI_ADDR_CORE_IRQ_EN2: rdata_nxt = core_en2_r;
      SSI_ADDR_SUPPLY_IRQ_EN: rdata_nxt = supply_en_r;
      SSI_ADDR_PERIPHERAL_CONFIG_CFG: rdata_nxt = peripheral_config_view;
      SSI_ADDR_SWITCHOVER_CFG: rdata_nxt = switch_cfg_r;
      SSI_ADDR_SUPPLY_IRQ_FLAGS: rdata_nxt = flags_view;
      SSI_ADDR_BAT_THRESHOLD: rdata_nxt = bat_thr_r;
      SSI_ADDR_IRQ_PIN_CFG: rdata_nxt = pin_cfg_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // outputs
  // every output is a flop; the interrupt lags the flags by one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_r <= 8'h00;
      conv_start_r <= 1'b0;
      supply_on_main_r <= 1'b1;
      supply_irq_r <= 1'b0;
    end else begin
      if (sfr_req.rd) begin
        sfr_rdata_r <= rdata_nxt;
      end
      conv_start_r <= wr_conv; // [R15]
      supply_on_main_r <= on_main_nxt;
      supply_irq_r <= core_en && (|pending); // [R8] [R20]
    end
  end
endmodule

// file: test/ssi_top_properties.sv
// concurrent checks on the ports of the supply switchover block
`timescale 1ns/1ps
module ssi_top_properties import ssi_pkg::*; #(
  parameter int unsigned QUAL_CYCLES = SSI_QUAL_CYCLES_DEF,
  parameter bit HAS_MONITORS = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire ssi_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata_r,
  // comparators and pin
  input wire logic main_above_th,
  input wire logic dc_above_th,
  input wire logic battery_control_pin,
  // converters and outputs
  input wire ssi_adc_s adc_in,
  input wire logic conv_start_r,
  input wire logic supply_on_main_r,
  input wire logic supply_irq_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadows of what the core wrote, and how long main has been good
  logic [1:0] sel_r;
  logic core_en_r;
  logic [7:0] ie_r;
  logic [31:0] hi_cnt_r;
  wire wr_w = sfr_req.wr;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= 2'h0;
      core_en_r <= 1'b0;
      ie_r <= 8'h00;
      hi_cnt_r <= 32'h0000_0000;
    end else begin
      if (wr_w && sfr_req.addr == SSI_ADDR_SWITCHOVER_CFG) sel_r <= sfr_req.wdata[1:0];
      if (wr_w && sfr_req.addr == SSI_ADDR_CORE_IRQ_EN2) core_en_r <= sfr_req.wdata[SSI_BIT_CORE_EN];
      if (wr_w && sfr_req.addr == SSI_ADDR_SUPPLY_IRQ_EN) ie_r <= sfr_req.wdata;
      hi_cnt_r <= main_above_th ? hi_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  property p_conv_start;
    wr_w && sfr_req.addr == SSI_ADDR_CONV_START |=> conv_start_r;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("no conversion start pulse");
  property p_trip_main;
    (sel_r == SSI_SRC_MAIN_ONLY && !main_above_th) [*3] |=> !supply_on_main_r;
  endproperty
  a_trip_main: assert property (p_trip_main) else $error("main low did not move supply");
  property p_trip_dc;
    (sel_r == SSI_SRC_DC_INPUT && !dc_above_th) [*3] |=> !supply_on_main_r;
  endproperty
  a_trip_dc: assert property (p_trip_dc) else $error("dc input low did not move supply");
  property p_irq_mask;
    !core_en_r && !$past(core_en_r) |-> !supply_irq_r;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt without core enable");
  property p_bso_irq;
    $fell(supply_on_main_r) && core_en_r && ie_r[1] |=> supply_irq_r;
  endproperty
  a_bso_irq: assert property (p_bso_irq) else $error("no switchover interrupt");
  property p_psr_irq;
    $rose(supply_on_main_r) && core_en_r && ie_r[7] |=> supply_irq_r;
  endproperty
  a_psr_irq: assert property (p_psr_irq) else $error("no restore interrupt");
  property p_qual;
    $rose(supply_on_main_r) && !sel_r[1] |-> hi_cnt_r >= QUAL_CYCLES;
  endproperty
  a_qual: assert property (p_qual) else $error("restore before qualification time");
  property p_src_ind;
    sfr_req.rd && sfr_req.addr == SSI_ADDR_PERIPHERAL_CONFIG_CFG |=> sfr_rdata_r[6] == $past(supply_on_main_r);
  endproperty
  a_src_ind: assert property (p_src_ind) else $error("source indicator wrong");
  c_trip: cover property ($fell(supply_on_main_r));
  c_restore: cover property ($rose(supply_on_main_r));
  c_irq: cover property ($rose(supply_irq_r));
endmodule
bind ssi_top ssi_top_properties #(.QUAL_CYCLES(QUAL_CYCLES), .HAS_MONITORS(HAS_MONITORS)) chk_u (
  .clk(clk), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata_r(sfr_rdata_r),
  .main_above_th(main_above_th), .dc_above_th(dc_above_th), .battery_control_pin(battery_control_pin),
  .adc_in(adc_in), .conv_start_r(conv_start_r), .supply_on_main_r(supply_on_main_r),
  .supply_irq_r(supply_irq_r)
);

// file: test/ssi_afe_model.sv
// model of the comparators, battery control pin and monitor converters
`timescale 1ns/1ps
module ssi_afe_model import ssi_pkg::*; (
  // clock and conversion request
  input wire logic clk,
  input wire logic conv_start_r,
  // levels and events toward the block
  output logic main_above_th,
  output logic dc_above_th,
  output logic battery_control_pin,
  output ssi_adc_s adc_in
);
  initial begin
    main_above_th = 1'b1;
    dc_above_th = 1'b1;
    battery_control_pin = 1'b1;
    adc_in = '0;
  end
  task automatic levels(input logic m, input logic d, input logic p);
    @(posedge clk);
    main_above_th <= m;
    dc_above_th <= d;
    battery_control_pin <= p;
  endtask
  task automatic events(input logic bat, input logic dip, input logic dlt);
    @(posedge clk);
    adc_in.bat_valid <= bat;
    adc_in.bat_result <= 8'h10;
    adc_in.line_dip <= dip;
    adc_in.dc_delta <= dlt;
    @(posedge clk);
    adc_in.bat_valid <= 1'b0;
    adc_in.line_dip <= 1'b0;
    adc_in.dc_delta <= 1'b0;
  endtask
  // a started conversion reports its result on the next cycle
  always @(posedge clk) adc_in.dc_ready <= conv_start_r;
endmodule

// file: test/ssi_top_tb_top.sv
// self-checking bench for the supply switchover and interrupt block
`timescale 1ns/1ps
module ssi_top_tb_top import ssi_pkg::*; ;
  localparam int unsigned QUAL = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ssi_sfr_req_s sfr_req = '0;
  logic [7:0] sfr_rdata_r;
  logic [7:0] red_rdata;
  logic main_above_th, dc_above_th, battery_control_pin, conv_start_r, supply_on_main_r, supply_irq_r;
  ssi_adc_s adc_in;
  int err_count = 0;
  int checked = 0;
  logic [7:0] ra [8] = '{SSI_ADDR_CORE_IRQ_EN2, SSI_ADDR_SUPPLY_IRQ_EN, SSI_ADDR_PERIPHERAL_CONFIG_CFG,
    SSI_ADDR_SWITCHOVER_CFG, SSI_ADDR_SUPPLY_IRQ_FLAGS, SSI_ADDR_IRQ_PIN_CFG, SSI_ADDR_CONV_START, 8'h00};
  ssi_top #(.QUAL_CYCLES(QUAL), .HAS_MONITORS(1'b1)) dut_u (.clk(clk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_rdata_r(sfr_rdata_r), .main_above_th(main_above_th),
    .dc_above_th(dc_above_th), .battery_control_pin(battery_control_pin), .adc_in(adc_in),
    .conv_start_r(conv_start_r), .supply_on_main_r(supply_on_main_r), .supply_irq_r(supply_irq_r));
  // reduced variant on the same stimulus, compared through its read data
  ssi_top #(.QUAL_CYCLES(QUAL), .HAS_MONITORS(1'b0)) red_u (.clk(clk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_rdata_r(red_rdata), .main_above_th(main_above_th),
    .dc_above_th(dc_above_th), .battery_control_pin(battery_control_pin), .adc_in(adc_in),
    .conv_start_r(), .supply_on_main_r(), .supply_irq_r());
  ssi_afe_model afe_u (.clk(clk), .conv_start_r(conv_start_r), .main_above_th(main_above_th),
    .dc_above_th(dc_above_th), .battery_control_pin(battery_control_pin), .adc_in(adc_in));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one register access: strobe for one cycle, then settle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    sfr_req.wr <= 1'b0;
    sfr_req.rd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp8(sfr_rdata_r, e);
  endtask
  task automatic wsup(input logic v);
    int i;
    i = 0;
    while (supply_on_main_r !== v) begin
      @(posedge clk);
      #1;
      i++;
      if (i > QUAL * 3) begin
        cmp1(supply_on_main_r, v);
        end_sim();
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i]) rd(ra[i], (ra[i] == SSI_ADDR_PERIPHERAL_CONFIG_CFG) ? 8'h40 : 8'h00);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00);
    wr(SSI_ADDR_BAT_THRESHOLD, 8'h5A);
    rd(SSI_ADDR_BAT_THRESHOLD, 8'h5A);
    cmp1(supply_irq_r, 1'b0);
    $display("test reset done");
    wr(SSI_ADDR_CORE_IRQ_EN2, 8'h02);
    wr(SSI_ADDR_SUPPLY_IRQ_EN, 8'h82);
    afe_u.levels(1'b0, 1'b1, 1'b1);
    wsup(1'b0);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h42);
    rd(SSI_ADDR_PERIPHERAL_CONFIG_CFG, 8'h00);
    cmp1(supply_irq_r, 1'b1);
    afe_u.levels(1'b1, 1'b1, 1'b1);
    wsup(1'b1);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'hC2);
    wr(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    cmp1(supply_irq_r, 1'b0);
    $display("test main switchover done");
    wr(SSI_ADDR_SUPPLY_IRQ_EN, 8'h00);
    afe_u.levels(1'b0, 1'b1, 1'b1);
    wsup(1'b0);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h02);
    cmp1(supply_irq_r, 1'b0);
    afe_u.levels(1'b1, 1'b1, 1'b1);
    wsup(1'b1);
    wr(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    $display("test masked done");
    wr(SSI_ADDR_SWITCHOVER_CFG, 8'h01);
    afe_u.levels(1'b1, 1'b0, 1'b1);
    wsup(1'b0);
    repeat (QUAL + 10) @(posedge clk);
    #1;
    cmp1(supply_on_main_r, 1'b0);
    afe_u.levels(1'b1, 1'b1, 1'b1);
    wsup(1'b1);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h83);
    wr(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    wr(SSI_ADDR_SWITCHOVER_CFG, 8'h00);
    $display("test dc input done");
    wr(SSI_ADDR_IRQ_PIN_CFG, 8'h02);
    afe_u.levels(1'b1, 1'b1, 1'b0);
    wsup(1'b0);
    repeat (QUAL + 10) @(posedge clk);
    #1;
    cmp1(supply_on_main_r, 1'b0);
    afe_u.levels(1'b1, 1'b1, 1'b1);
    wsup(1'b1);
    wr(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    wr(SSI_ADDR_IRQ_PIN_CFG, 8'h00);
    $display("test pin done");
    wr(SSI_ADDR_SUPPLY_IRQ_EN, 8'h2C);
    wr(SSI_ADDR_CONV_START, 8'h01);
    repeat (3) @(posedge clk);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h48);
    wr(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h00);
    afe_u.events(1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    rd(SSI_ADDR_SUPPLY_IRQ_FLAGS, 8'h6C);
    cmp8(red_rdata, 8'h60);
    cmp1(supply_irq_r, 1'b1);
    rd(SSI_ADDR_SUPPLY_IRQ_EN, 8'h2C);
    cmp8(red_rdata, 8'h20);
    wr(SSI_ADDR_CORE_IRQ_EN2, 8'h00);
    @(posedge clk);
    #1;
    cmp1(supply_irq_r, 1'b0);
    $display("test monitors done");
    end_sim();
  end
endmodule
